/* rtl/nsr_pkg.sv */
// Constants for the stored-settings readback command handler
package nsr_pkg;
  localparam int REPORT_LEN = 64;
  localparam logic [5:0] LAST_IDX = 6'h3f;
  localparam logic [7:0] CMD_READ_SETTINGS = 8'h61;
  localparam logic [7:0] SUB_CHIP_SETTINGS = 8'h20;
  localparam logic [7:0] SUB_KEY_PARAMS = 8'h30;
  localparam logic [7:0] STATUS_OK = 8'h00;
  localparam logic [7:0] STATUS_UNKNOWN = 8'hf8;
  localparam logic [7:0] DONT_CARE = 8'h00;
  // Reply byte positions
  localparam logic [5:0] IDX_CMD = 6'h00;
  localparam logic [5:0] IDX_STATUS = 6'h01;
  localparam logic [5:0] IDX_SUB = 6'h02;
  localparam logic [5:0] IDX_PIN7_DESIG = 6'h0b;
  localparam logic [5:0] IDX_INPIN_DESIG = 6'h0c;
  localparam logic [5:0] IDX_DEF_OUT = 6'h0d;
  localparam logic [5:0] IDX_DEF_DIR = 6'h0f;
  localparam logic [5:0] IDX_OPTIONS = 6'h11;
  localparam logic [5:0] IDX_PROTECT = 6'h12;
  localparam logic [5:0] IDX_VID_LO = 6'h0c;
  localparam logic [5:0] IDX_VID_HI = 6'h0d;
  localparam logic [5:0] IDX_PID_LO = 6'h0e;
  localparam logic [5:0] IDX_PID_HI = 6'h0f;
  localparam logic [5:0] IDX_POWER = 6'h1d;
  localparam logic [5:0] IDX_CURRENT = 6'h1e;
  // Option and power byte field positions
  localparam int WAKE_BIT = 4;
  localparam int INT_MODE_LSB = 1;
  localparam int RELEASE_BIT = 0;
  localparam int PWR_BUS_BIT = 7;
  localparam int PWR_SELF_BIT = 6;
  localparam int PWR_WAKE_BIT = 5;
  // Encodings
  localparam logic [7:0] DESIG_GPIO = 8'h00;
  localparam logic [7:0] DESIG_CS = 8'h01;
  localparam logic [7:0] DESIG_DEDICATED = 8'h02;
  localparam logic [2:0] INT_NONE = 3'h0;
  localparam logic [2:0] INT_FALL = 3'h1;
  localparam logic [2:0] INT_RISE = 3'h2;
  localparam logic [2:0] INT_LOW = 3'h3;
  localparam logic [2:0] INT_HIGH = 3'h4;
  localparam logic [7:0] PROT_NONE = 8'h00;
  localparam logic [7:0] PROT_PASSWORD = 8'h40;
  localparam logic [7:0] PROT_LOCKED = 8'h80;
  typedef enum logic [1:0] {
    NSR_COLLECT = 2'b00,
    NSR_REPLY = 2'b01
  } nsr_state_t;
endpackage

/* rtl/nsr_readback.sv */
// Stored-settings readback command handler: takes a 64-byte report, returns a 64-byte reply
// Operation
// - Byte 11 gives pin seven designation (0x00/0x01/0x02), byte 12 the input-only pin (0x00/0x02).
// - Byte 13 gives default output levels of pins zero to seven, bit n for pin n, byte 14 don't care.
// - Byte 15 gives default direction bits of pins zero to seven, byte 16 don't care.
// - Byte 17 bit 4 gives remote wake-up enable, bits 7 to 5 don't care.
// - Byte 17 bits 3 to 1 give the interrupt counting mode, codes 101 to 111 reserved.
// - Byte 17 bit 0 gives serial bus release: 0 released, 1 held between transfers.
// - Byte 18 gives protection level 0x00, 0x40 or 0x80, bytes 19 to 63 don't care.
// - The key reply echoes the command, gives status 0x00 and echoes the sub-command.
// - Byte 29 gives power attributes: bit 7 bus, bit 6 self powered, bit 5 remote wake-up.
// - Byte 30 gives the requested current in units of 2 mA, the rest don't care.
`timescale 1ns/10ps
module nsr_readback (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Incoming report bytes, one per cycle
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  // Outgoing reply bytes, one per cycle
  output logic tx_valid,
  output logic [7:0] tx_byte,
  output logic tx_last,
  input wire logic tx_ready,
  // Stored chip settings
  input wire logic [7:0] pin_seven_designation,
  input wire logic [7:0] input_only_pin_designation,
  input wire logic [7:0] default_output,
  input wire logic [7:0] default_direction,
  input wire logic remote_wakeup_enable,
  input wire logic [2:0] interrupt_count_mode,
  input wire logic bus_hold_enable,
  input wire logic [7:0] protection_level,
  // Stored key parameters
  input wire logic [15:0] vendor_id,
  input wire logic [15:0] product_id,
  input wire logic bus_powered,
  input wire logic self_powered,
  input wire logic wakeup_capable,
  input wire logic [7:0] current_units,
  // Status
  output logic busy,
  output logic bad_request
);
  nsr_pkg::nsr_state_t state_reg, state_next;
  logic [5:0] idx_reg;
  logic [7:0] cmd_reg;
  logic [7:0] sub_reg;
  logic nonzero_reg;
  logic tx_valid_reg;
  logic [7:0] tx_byte_reg;
  logic tx_last_reg;
  logic bad_reg;
  logic busy_reg;

  // Final byte position of a 64-byte report
  function automatic logic at_last(input logic [5:0] i);
    return i == nsr_pkg::LAST_IDX;
  endfunction

  // Accept and step strobes for the report being collected or replied
  wire rx_take = (state_reg == nsr_pkg::NSR_COLLECT) && rx_valid;
  wire rx_done = rx_take && at_last(idx_reg);
  wire tx_step = (state_reg == nsr_pkg::NSR_REPLY) && (!tx_valid_reg || tx_ready);
  wire reply_end = tx_valid_reg && tx_ready && tx_last_reg;
  wire rx_nonzero = rx_take && (idx_reg > nsr_pkg::IDX_SUB - 6'h01) && (rx_byte != 8'h00);

  // Reserved bytes that are not zero mark the request malformed
  wire is_read = (cmd_reg == nsr_pkg::CMD_READ_SETTINGS) && !nonzero_reg;
  wire is_chip = is_read && (sub_reg == nsr_pkg::SUB_CHIP_SETTINGS);
  wire is_key = is_read && (sub_reg == nsr_pkg::SUB_KEY_PARAMS);
  wire is_known = is_chip || is_key;

  // Option byte fields; reserved counting codes pass through as stored
  function automatic logic [7:0] option_bits(input logic wake, input logic [2:0] mode, input logic hold);
    logic [7:0] b;
    b = nsr_pkg::DONT_CARE;
    b[nsr_pkg::WAKE_BIT] = wake;
    b[nsr_pkg::INT_MODE_LSB +: 3] = mode;
    b[nsr_pkg::RELEASE_BIT] = hold;
    return b;
  endfunction

  // Power attribute fields, low five bits read as zero
  function automatic logic [7:0] power_bits(input logic host_pwr, input logic own_pwr, input logic wake);
    logic [7:0] b;
    b = nsr_pkg::DONT_CARE;
    b[nsr_pkg::PWR_BUS_BIT] = host_pwr;
    b[nsr_pkg::PWR_SELF_BIT] = own_pwr;
    b[nsr_pkg::PWR_WAKE_BIT] = wake;
    return b;
  endfunction

  wire [7:0] options_byte = option_bits(remote_wakeup_enable, interrupt_count_mode, bus_hold_enable);
  wire [7:0] power_byte = power_bits(bus_powered, self_powered, wakeup_capable);

  // Chip-settings body; unlisted positions read as zero
  function automatic logic [7:0] chip_byte(input logic [5:0] i);
    unique case (i)
      nsr_pkg::IDX_PIN7_DESIG: chip_byte = pin_seven_designation;
      nsr_pkg::IDX_INPIN_DESIG: chip_byte = input_only_pin_designation;
      nsr_pkg::IDX_DEF_OUT: chip_byte = default_output;
      nsr_pkg::IDX_DEF_DIR: chip_byte = default_direction;
      nsr_pkg::IDX_OPTIONS: chip_byte = options_byte;
      nsr_pkg::IDX_PROTECT: chip_byte = protection_level;
      default: chip_byte = nsr_pkg::DONT_CARE;
    endcase
  endfunction

  // Key-parameters body; unlisted positions read as zero
  function automatic logic [7:0] key_byte(input logic [5:0] i);
    unique case (i)
      nsr_pkg::IDX_VID_LO: key_byte = vendor_id[7:0];
      nsr_pkg::IDX_VID_HI: key_byte = vendor_id[15:8];
      nsr_pkg::IDX_PID_LO: key_byte = product_id[7:0];
      nsr_pkg::IDX_PID_HI: key_byte = product_id[15:8];
      nsr_pkg::IDX_POWER: key_byte = power_byte;
      nsr_pkg::IDX_CURRENT: key_byte = current_units;
      default: key_byte = nsr_pkg::DONT_CARE;
    endcase
  endfunction

  // Header bytes echo command and sub-command
  // Unknown or malformed requests still get a full reply, so the host never waits on a missing report
  wire [7:0] status_byte = is_known ? nsr_pkg::STATUS_OK : nsr_pkg::STATUS_UNKNOWN;
  wire [7:0] body_byte = is_chip ? chip_byte(idx_reg) : (is_key ? key_byte(idx_reg) : nsr_pkg::DONT_CARE);
  wire [7:0] reply_byte = (idx_reg == nsr_pkg::IDX_CMD) ? cmd_reg :
                          (idx_reg == nsr_pkg::IDX_STATUS) ? status_byte :
                          (idx_reg == nsr_pkg::IDX_SUB) ? sub_reg : body_byte;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      nsr_pkg::NSR_COLLECT: begin
        if (rx_done) begin
          state_next = nsr_pkg::NSR_REPLY;
        end
      end
      nsr_pkg::NSR_REPLY: begin
        if (reply_end) begin
          state_next = nsr_pkg::NSR_COLLECT;
        end
      end
      default: state_next = nsr_pkg::NSR_COLLECT;
    endcase
  end

  // Bytes arriving while replying are dropped silently; the host must wait for the reply
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg <= nsr_pkg::NSR_COLLECT;
    end else begin
      state_reg <= state_next;
    end
  end

  // Busy has its own flop so the port carries no decode
  always_ff @(posedge mclk) begin
    if (reset) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= (state_next == nsr_pkg::NSR_REPLY);
    end
  end

  // Index wraps to zero at the end of each phase since 64 fits six bits exactly
  always_ff @(posedge mclk) begin
    if (reset) begin
      idx_reg <= 6'h00;
    end else if (rx_take || (tx_step && !(tx_valid_reg && tx_last_reg))) begin
      idx_reg <= idx_reg + 6'h01;
    end
  end

  // Only the first two bytes are kept; later bytes need just a zero test
  always_ff @(posedge mclk) begin
    if (reset) begin
      cmd_reg <= 8'h00;
      sub_reg <= 8'h00;
      nonzero_reg <= 1'b0;
    end else if (rx_take) begin
      if (idx_reg == nsr_pkg::IDX_CMD) begin
        cmd_reg <= rx_byte;
        nonzero_reg <= 1'b0;
      end else if (idx_reg == nsr_pkg::IDX_STATUS) begin
        sub_reg <= rx_byte;
      end else if (rx_nonzero) begin
        nonzero_reg <= 1'b1;
      end
    end
  end

  // Reply stage; holds its byte until the far end takes it
  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_valid_reg <= 1'b0;
      tx_byte_reg <= 8'h00;
      tx_last_reg <= 1'b0;
    end else if (reply_end) begin
      tx_valid_reg <= 1'b0;
      tx_last_reg <= 1'b0;
    end else if (tx_step) begin
      tx_valid_reg <= 1'b1;
      tx_byte_reg <= reply_byte;
      tx_last_reg <= at_last(idx_reg);
    end
  end

  // Byte 63 is folded in directly since nonzero_reg lags it by one edge
  always_ff @(posedge mclk) begin
    if (reset) begin
      bad_reg <= 1'b0;
    end else if (rx_done) begin
      bad_reg <= !is_known || rx_nonzero;
    end
  end

  assign tx_valid = tx_valid_reg;
  assign tx_byte = tx_byte_reg;
  assign tx_last = tx_last_reg;
  assign busy = busy_reg;
  assign bad_request = bad_reg;
endmodule

/* test/nsr_readback_monitor.sv */
// Port-level checker for the readback handler
`timescale 1ns/10ps
module nsr_readback_monitor (
  // Clock, reset, reply side
  input wire logic mclk,
  input wire logic reset,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_last,
  input wire logic tx_ready,
  input wire logic busy,
  // Stored values
  input wire logic remote_wakeup_enable,
  input wire logic [2:0] interrupt_count_mode,
  input wire logic bus_hold_enable,
  input wire logic [7:0] protection_level,
  input wire logic [15:0] product_id,
  input wire logic bus_powered,
  input wire logic self_powered,
  input wire logic wakeup_capable
);
  logic [5:0] idx_reg;
  logic [7:0] sub_reg;
  logic ok_reg;
  wire take = tx_valid && tx_ready;
  // Body checks only on good replies, status seen at byte 1
  wire chip = tx_valid && ok_reg && sub_reg == 8'h20;
  wire key = tx_valid && ok_reg && sub_reg == 8'h30;
  wire [7:0] options_exp = {3'h0, remote_wakeup_enable, interrupt_count_mode, bus_hold_enable};
  wire [7:0] power_exp = {bus_powered, self_powered, wakeup_capable, 5'h00};
  always_ff @(posedge mclk) begin
    if (reset) begin
      idx_reg <= 6'h00;
      ok_reg <= 1'b0;
      sub_reg <= 8'h00;
    end else if (take) begin
      idx_reg <= idx_reg + 6'h01;
      if (idx_reg == 6'h01) ok_reg <= tx_byte == 8'h00;
      if (idx_reg == 6'h02) sub_reg <= tx_byte;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence take_last;
    tx_valid && tx_ready && tx_last;
  endsequence
  sequence reply_start;
    $rose(busy);
  endsequence
  last_flag_a: assert property (tx_valid |-> tx_last == (idx_reg == 6'h3f))
    else $error("bad last");
  hold_byte_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("byte moved");
  reply_lead_a: assert property (reply_start |-> !tx_valid ##1 tx_valid)
    else $error("bad lead");
  reply_end_a: assert property (take_last |=> !tx_valid && !busy)
    else $error("no idle");
  busy_cover_a: assert property (tx_valid |-> busy)
    else $error("valid idle");
  option_byte_a: assert property (chip && idx_reg == 6'h11 |-> tx_byte == options_exp)
    else $error("bad options");
  protect_byte_a: assert property (chip && idx_reg == 6'h12 |-> tx_byte == protection_level)
    else $error("bad prot");
  pid_high_a: assert property (key && idx_reg == 6'h0f |-> tx_byte == product_id[15:8])
    else $error("bad pid");
  power_byte_a: assert property (key && idx_reg == 6'h1d |-> tx_byte == power_exp)
    else $error("bad power");
endmodule

/* test/nsr_host_model.sv */
// Host model: sends one request report and collects the reply with random stalls
`timescale 1ns/10ps
module nsr_host_model (
  input wire logic mclk,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_ready
);
  logic [7:0] rep [64];
  bit hung;
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    tx_ready = 1'b0;
  end
  // Pad slot at byte 9 builds malformed requests
  task automatic xfer(input logic [7:0] c, s, pad);
    int i;
    int t;
    for (i = 0; i < 64; i++) begin
      @(posedge mclk);
      #1 rx_valid = 1'b1;
      rx_byte = i == 0 ? c : i == 1 ? s : i == 9 ? pad : 8'h00;
    end
    @(posedge mclk);
    #1 rx_valid = 1'b0;
    rx_byte = ~rx_byte;
    i = 0;
    t = 0;
    while (i < 64 && t < 400) begin
      tx_ready = $urandom_range(2) != 0;
      @(posedge mclk);
      if (tx_valid && tx_ready) begin
        rep[i] = tx_byte;
        i++;
      end
      t++;
      #1;
    end
    tx_ready = 1'b0;
    hung = i < 64;
  endtask
endmodule

/* test/nsr_readback_test.sv */
// Testbench for the readback handler
`timescale 1ns/10ps
module nsr_readback_test;
  logic mclk, reset, rx_valid, tx_valid, tx_last, tx_ready, busy, bad_request, remote_wakeup_enable;
  logic bus_hold_enable, bus_powered, self_powered, wakeup_capable;
  logic [7:0] rx_byte, tx_byte, pin_seven_designation, input_only_pin_designation, default_output;
  logic [7:0] default_direction, protection_level, current_units;
  logic [2:0] interrupt_count_mode;
  logic [15:0] vendor_id, product_id;
  int err_count = 0;
  int n_checks = 0;
  nsr_readback dut (.*);
  nsr_host_model host (.*);
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task wrap_up;
    if (err_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task cmp_flag(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask
  function automatic logic [7:0] exp_byte(input logic [7:0] c, s, input bit ok, input int i);
    if (i < 3) return i == 0 ? c : i == 1 ? (ok ? 8'h00 : 8'hf8) : s;
    if (!ok) return 8'h00;
    if (s == 8'h20) return i == 11 ? pin_seven_designation : i == 12 ? input_only_pin_designation :
      i == 13 ? default_output : i == 15 ? default_direction : i == 18 ? protection_level :
      i == 17 ? {3'h0, remote_wakeup_enable, interrupt_count_mode, bus_hold_enable} : 8'h00;
    return i == 12 ? vendor_id[7:0] : i == 13 ? vendor_id[15:8] : i == 14 ? product_id[7:0] :
      i == 15 ? product_id[15:8] : i == 30 ? current_units :
      i == 29 ? {bus_powered, self_powered, wakeup_capable, 5'h00} : 8'h00;
  endfunction
  initial begin
    int k;
    int i;
    logic [7:0] c, s, pd;
    bit ok;
    reset = 1'b1;
    k = $urandom(32'hb8073942);
    // Even passes read chip settings, odd ones key parameters; last three are refused
    for (k = 0; k < 12; k++) begin
      c = k == 11 ? 8'h70 : 8'h61;
      s = k == 9 ? 8'h40 : k[0] ? 8'h30 : 8'h20;
      pd = k == 10 ? 8'h5a : 8'h00;
      pin_seven_designation = 8'(k % 3);
      input_only_pin_designation = k[1] ? 8'h02 : 8'h00;
      interrupt_count_mode = 3'(k % 5);
      protection_level = 8'(64 * (k % 3));
      {default_output, default_direction, current_units} = 24'($urandom);
      {vendor_id, product_id} = $urandom;
      {remote_wakeup_enable, bus_hold_enable, bus_powered, self_powered, wakeup_capable} = 5'($urandom);
      if (k == 0) begin
        repeat (4) @(posedge mclk);
        #1 reset = 1'b0;
      end
      // Mid-run reset right after the refused sub-command pass must clear the error flag
      if (k == 10) begin
        reset = 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        cmp_flag("bad_request", 1'b0, bad_request);
        cmp_flag("busy", 1'b0, busy);
        cmp_flag("tx_valid", 1'b0, tx_valid);
        cmp_flag("tx_last", 1'b0, tx_last);
        cmp8("tx_byte", 8'h00, tx_byte);
        reset = 1'b0;
      end
      host.xfer(c, s, pd);
      if (host.hung) begin
        err_count++;
        wrap_up;
      end
      ok = c == 8'h61 && pd == 8'h00 && (s == 8'h20 || s == 8'h30);
      for (i = 0; i < 64; i++) begin
        cmp8("reply byte", exp_byte(c, s, ok, i), host.rep[i]);
      end
      cmp_flag("bad_request", !ok, bad_request);
    end
    wrap_up;
  end
endmodule
bind nsr_readback nsr_readback_monitor mon (.*);
